// ---- src/sed_debug_ctrl.sv ----
// Behaviour
// - EXT_DEBUG_MODE_EN set via test port blocks software writes
// - Enabled events halt CPU under EXT_DEBUG_MODE_EN
// - No debug interrupt while EXT_DEBUG_MODE_EN set
// - First EXT_DEBUG_MODE_EN set keeps other control bits; a bus write that sets it writes the other bits too
// - Emulation disabled blocks EXT_DEBUG_MODE_EN, entry, events; events only while the bit is set, and the bit still blocks software writes
// - Read data resampled into test clock timing
// - Control bit requests CPU clock on
// - Sixteen-state standard TAP controller
// - No boundary cells; public instructions signalled
// - Scanned instruction executes as normal instruction
// - First debug entry starts session, flags shown
// - Go-stay runs one instruction, stays halted
// - Go-exit ends session unless request pending; the code clears the session flag on every go-exit
// - Debug entry halts at recoverable boundary
// - Debug registers readable, writable over test port
// - Entry via request bit, go-stay or pin
// - Test data enable only in shift states
// - Debug request answered by CPU acknowledge
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "sed_regs.svh"
module sed_debug_ctrl (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Test port pins
	input  wire logic        tck_i,
	input  wire logic        tms_i,
	input  wire logic        tdi_i,
	input  wire logic        trst_n_i,
	output logic             tdo_o,
	output logic             tdo_en_o,
	// CPU and system
	input  wire logic        emu_enable_in_i,
	input  wire logic        ext_debug_entry_n_i,
	input  wire logic        dbg_ack_i,
	input  wire logic [7:0]  dbg_event_i,
	output logic             dbg_req_o,
	output logic             debug_irq_o,
	output logic             exec_o,
	output logic      [31:0] exec_instr_o,
	output logic             debug_session_n_o,
	output logic             cpu_clk_req_o,
	output logic             public_instr_o,
	output logic             ext_debug_mode_en_o
);
	// Pin synchronisers, two stages each
	logic [`SED_NSYNC-1:0] pin_raw, sync1_q, sync2_q;
	assign pin_raw = {ext_debug_entry_n_i, emu_enable_in_i, trst_n_i, tdi_i, tms_i, tck_i};
	// Reset to idle levels so no false tck edge follows reset
	localparam logic [`SED_NSYNC-1:0] SYNC_IDLE = `SED_SYNC_IDLE;
	genvar gi;
	generate
		for (gi = 0; gi < `SED_NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1_q[gi] <= SYNC_IDLE[gi];
					sync2_q[gi] <= SYNC_IDLE[gi];
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate
	logic tck_s, tms_s, tdi_s, trst_n_s, emu_en_s, ext_entry_n_s, tck_prev_q;
	assign {ext_entry_n_s, emu_en_s, trst_n_s, tdi_s, tms_s, tck_s} = sync2_q;
	logic tck_rise, tck_fall;
	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;

	// TAP group
	sed_pkg::sed_tap_t tap_q, tap_d;
	sed_pkg::sed_cmd_t ir_q, ir_d;
	logic [`SED_DR_LEN-1:0] sh_q, sh_d;
	logic tdo_q, tdo_d, pub_q, pub_d;
	logic [31:0] jt_rdata;
	logic [7:0] estat;
	logic jt_upd;
	always_comb begin
		tap_d = tap_q;
		ir_d  = ir_q;
		sh_d  = sh_q;
		tdo_d = tdo_q;
		pub_d = pub_q;
		if (tck_rise) begin
			case (tap_q)
				sed_pkg::TLR:    tap_d = tms_s ? sed_pkg::TLR    : sed_pkg::RTI;
				sed_pkg::RTI:    tap_d = tms_s ? sed_pkg::SEL_DR : sed_pkg::RTI;
				sed_pkg::SEL_DR: tap_d = tms_s ? sed_pkg::SEL_IR : sed_pkg::CAP_DR;
				sed_pkg::CAP_DR: tap_d = tms_s ? sed_pkg::EX1_DR : sed_pkg::SHF_DR;
				sed_pkg::SHF_DR: tap_d = tms_s ? sed_pkg::EX1_DR : sed_pkg::SHF_DR;
				sed_pkg::EX1_DR: tap_d = tms_s ? sed_pkg::UPD_DR : sed_pkg::PAU_DR;
				sed_pkg::PAU_DR: tap_d = tms_s ? sed_pkg::EX2_DR : sed_pkg::PAU_DR;
				sed_pkg::EX2_DR: tap_d = tms_s ? sed_pkg::UPD_DR : sed_pkg::SHF_DR;
				sed_pkg::UPD_DR: tap_d = tms_s ? sed_pkg::SEL_DR : sed_pkg::RTI;
				sed_pkg::SEL_IR: tap_d = tms_s ? sed_pkg::TLR    : sed_pkg::CAP_IR;
				sed_pkg::CAP_IR: tap_d = tms_s ? sed_pkg::EX1_IR : sed_pkg::SHF_IR;
				sed_pkg::SHF_IR: tap_d = tms_s ? sed_pkg::EX1_IR : sed_pkg::SHF_IR;
				sed_pkg::EX1_IR: tap_d = tms_s ? sed_pkg::UPD_IR : sed_pkg::PAU_IR;
				sed_pkg::PAU_IR: tap_d = tms_s ? sed_pkg::EX2_IR : sed_pkg::PAU_IR;
				sed_pkg::EX2_IR: tap_d = tms_s ? sed_pkg::UPD_IR : sed_pkg::SHF_IR;
				sed_pkg::UPD_IR: tap_d = tms_s ? sed_pkg::SEL_DR : sed_pkg::RTI;
				default:         tap_d = sed_pkg::TLR;
			endcase
			case (tap_q)
				// Read data taken from the system side at capture time
				sed_pkg::CAP_DR: sh_d = jt_rdata;
				sed_pkg::CAP_IR: sh_d = {24'h00_0000, estat};
				sed_pkg::SHF_DR: sh_d = (ir_q == `SED_IR_BYPASS) ? {31'h0000_0000, tdi_s}
				                                                  : {tdi_s, sh_q[31:1]};
				sed_pkg::SHF_IR: sh_d = {24'h00_0000, tdi_s, sh_q[7:1]};
				sed_pkg::UPD_IR: begin
					ir_d  = sh_q[7:0];
					pub_d = (sh_q[7:0] == `SED_IR_EXTEST) || (sh_q[7:0] == `SED_IR_SAMPLE);
				end
				default: ;
			endcase
		end
		if (tck_fall) begin
			tdo_d = sh_q[0];
		end
		if (!trst_n_s) begin
			tap_d = sed_pkg::TLR;
			ir_d  = `SED_RST_IR;
			pub_d = 1'b0;
		end else if (tap_q == sed_pkg::TLR) begin
			ir_d  = `SED_RST_IR;
			pub_d = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tap_q      <= sed_pkg::TLR;
			ir_q       <= `SED_RST_IR;
			sh_q       <= `SED_RST_WORD;
			tdo_q      <= 1'b0;
			pub_q      <= 1'b0;
			tck_prev_q <= 1'b0;
		end else begin
			tap_q      <= tap_d;
			ir_q       <= ir_d;
			sh_q       <= sh_d;
			tdo_q      <= tdo_d;
			pub_q      <= pub_d;
			tck_prev_q <= tck_s;
		end
	end
	assign tdo_o          = tdo_q;
	assign tdo_en_o       = (tap_q == sed_pkg::SHF_DR) || (tap_q == sed_pkg::SHF_IR);
	assign public_instr_o = pub_q;
	assign jt_upd         = tck_rise && (tap_q == sed_pkg::UPD_DR) && (ir_q != `SED_IR_BYPASS);

	// Debug register group
	logic [31:0] ctrl0_q, ctrl0_d, stat_q, stat_d, cnt_q, cnt_d, dac_q, dac_d;
	logic [31:0] scan_q, scan_d, iac_q [4], iac_d [4];
	logic [1:0] ectl_q, ectl_d;
	logic sess_q, sess_d, stay_q, stay_d, ack_prev_q, exec_q, exec_d, ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic ext_debug_mode_en, edm_eff, ev_ok, jt_wr, go_cmd, wb_req, wb_wr;
	logic [31:0] wmask, wb_rd;
	sed_pkg::sed_wb_req_t wb;
	assign wb      = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
	assign ext_debug_mode_en     = ctrl0_q[`SED_EDM_BIT];
	assign edm_eff = ext_debug_mode_en & emu_en_s;
	assign ev_ok   = emu_en_s | ~ext_debug_mode_en;
	assign jt_wr   = jt_upd && !ir_q.rd;
	assign go_cmd  = jt_upd && ir_q.go && dbg_ack_i;
	assign wb_req  = wb.cyc && wb.stb && !ack_q;
	assign wb_wr   = wb_req && wb.we && !ext_debug_mode_en;
	assign wmask   = {{8{wb.sel[3]}}, {8{wb.sel[2]}}, {8{wb.sel[1]}}, {8{wb.sel[0]}}};
	assign estat   = {4'h0, stay_q, edm_eff, sess_q, dbg_ack_i};
	always_comb begin
		case (ir_q.sel)
			`SED_SEL_CTRL0:      jt_rdata = ctrl0_q;
			`SED_SEL_STAT:       jt_rdata = stat_q;
			`SED_SEL_CNT:        jt_rdata = cnt_q;
			`SED_SEL_DAC:        jt_rdata = dac_q;
			`SED_SEL_SCAN:       jt_rdata = scan_q;
			`SED_SEL_ECTL:       jt_rdata = {30'h0000_0000, ectl_q};
			`SED_SEL_IAC,
			`SED_SEL_IAC + 5'h01,
			`SED_SEL_IAC + 5'h02,
			`SED_SEL_IAC + 5'h03: jt_rdata = iac_q[ir_q.sel[1:0]];
			default:             jt_rdata = `SED_RST_WORD;
		endcase
		case (wb.adr)
			`SED_ADR_CTRL0:         wb_rd = ctrl0_q;
			`SED_ADR_STAT:          wb_rd = stat_q;
			`SED_ADR_CNT:           wb_rd = cnt_q;
			`SED_ADR_ESTAT:         wb_rd = {24'h00_0000, estat};
			`SED_ADR_DAC:           wb_rd = dac_q;
			`SED_ADR_IAC,
			`SED_ADR_IAC + 8'h04,
			`SED_ADR_IAC + 8'h08,
			`SED_ADR_IAC + 8'h0C:   wb_rd = iac_q[wb.adr[3:2]];
			default:                wb_rd = `SED_RST_WORD;
		endcase
	end
	always_comb begin
		ctrl0_d = ctrl0_q;
		stat_d  = stat_q;
		cnt_d   = cnt_q;
		dac_d   = dac_q;
		scan_d  = scan_q;
		ectl_d  = ectl_q;
		iac_d   = iac_q;
		sess_d  = sess_q;
		stay_d  = stay_q;
		exec_d  = 1'b0;
		ack_d   = wb_req;
		rdat_d  = wb_req ? wb_rd : `SED_RST_WORD;
		if (wb_wr) begin
			case (wb.adr)
				`SED_ADR_CTRL0: ctrl0_d = (ctrl0_q & ~wmask) | (wb.dat & wmask);
				`SED_ADR_STAT:  stat_d  = (stat_q & ~wmask) | (wb.dat & wmask);
				`SED_ADR_CNT:   cnt_d   = (cnt_q & ~wmask) | (wb.dat & wmask);
				`SED_ADR_DAC:   dac_d   = (dac_q & ~wmask) | (wb.dat & wmask);
				`SED_ADR_IAC, `SED_ADR_IAC + 8'h04, `SED_ADR_IAC + 8'h08, `SED_ADR_IAC + 8'h0C:
					iac_d[wb.adr[3:2]] = (iac_q[wb.adr[3:2]] & ~wmask) | (wb.dat & wmask);
				default: ;
			endcase
		end
		if (jt_wr) begin
			case (ir_q.sel)
				// First EXT_DEBUG_MODE_EN set touches nothing else in the control word
				`SED_SEL_CTRL0: ctrl0_d = ext_debug_mode_en ? sh_q
				                : {sh_q[`SED_EDM_BIT], ctrl0_q[`SED_EDM_BIT-1:0]};
				`SED_SEL_STAT:  stat_d  = sh_q;
				`SED_SEL_CNT:   cnt_d   = sh_q;
				`SED_SEL_DAC:   dac_d   = sh_q;
				`SED_SEL_SCAN:  scan_d  = sh_q;
				`SED_SEL_ECTL:  ectl_d  = sh_q[1:0];
				`SED_SEL_IAC, `SED_SEL_IAC + 5'h01, `SED_SEL_IAC + 5'h02, `SED_SEL_IAC + 5'h03:
					iac_d[ir_q.sel[1:0]] = sh_q;
				default: ;
			endcase
		end
		// Hardware set wins over any write of the status word
		if (ev_ok) begin
			stat_d = stat_d | {24'h00_0000, dbg_event_i & ctrl0_q[`SED_EV_N-1:0]};
		end
		if (dbg_ack_i && !ack_prev_q) begin
			sess_d = 1'b1;
			stay_d = 1'b0;
		end
		if (go_cmd) begin
			exec_d = 1'b1;
			stay_d = !ir_q.ex;
			if (ir_q.ex) begin
				sess_d = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_q    <= `SED_RST_WORD;
			stat_q     <= `SED_RST_WORD;
			cnt_q      <= `SED_RST_WORD;
			dac_q      <= `SED_RST_WORD;
			scan_q     <= `SED_RST_WORD;
			iac_q      <= '{default: `SED_RST_WORD};
			ectl_q     <= 2'h0;
			sess_q     <= 1'b0;
			stay_q     <= 1'b0;
			exec_q     <= 1'b0;
			ack_q      <= 1'b0;
			rdat_q     <= `SED_RST_WORD;
			ack_prev_q <= 1'b0;
		end else begin
			ctrl0_q    <= ctrl0_d;
			stat_q     <= stat_d;
			cnt_q      <= cnt_d;
			dac_q      <= dac_d;
			scan_q     <= scan_d;
			iac_q      <= iac_d;
			ectl_q     <= ectl_d;
			sess_q     <= sess_d;
			stay_q     <= stay_d;
			exec_q     <= exec_d;
			ack_q      <= ack_d;
			rdat_q     <= rdat_d;
			ack_prev_q <= dbg_ack_i;
		end
	end
	// Request sources; CPU halts at boundary and answers with ack
	assign dbg_req_o = emu_en_s & (ectl_q[`SED_ECTL_DR] | ~ext_entry_n_s | stay_q
	                   | (ext_debug_mode_en & |stat_q[`SED_EV_N-1:0]));
	assign debug_irq_o         = ~ext_debug_mode_en & ev_ok & |stat_q[`SED_EV_N-1:0];
	assign exec_o              = exec_q;
	assign exec_instr_o        = scan_q;
	assign debug_session_n_o   = ~sess_q;
	assign cpu_clk_req_o       = ectl_q[`SED_ECTL_CLK];
	assign ext_debug_mode_en_o = edm_eff;
	assign wb_ack_o            = ack_q;
	assign wb_dat_o            = rdat_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	tdo_shift_a: assert property (tdo_en_o |-> tap_q inside {sed_pkg::SHF_DR, sed_pkg::SHF_IR})
		else $error("tdo enable outside shift");
	trst_tlr_a: assert property (!trst_n_s |=> tap_q == sed_pkg::TLR)
		else $error("test reset ignored");
	irq_block_a: assert property (ext_debug_mode_en |-> !debug_irq_o)
		else $error("interrupt while edm set");
	emu_block_a: assert property (!emu_en_s |-> !dbg_req_o && !ext_debug_mode_en_o)
		else $error("request while emulation disabled");
	session_start_a: assert property ($rose(dbg_ack_i) |=> sess_q && !debug_session_n_o)
		else $error("session not started");
	go_exit_a: assert property (go_cmd && ir_q.ex |=> !sess_q ##1 !exec_o)
		else $error("session not ended");
	sw_block_a: assert property (ext_debug_mode_en && wb_req && wb.we && !jt_wr && wb.adr == `SED_ADR_CNT
		|=> $stable(cnt_q))
		else $error("software write under edm");
	edm_keep_a: assert property (jt_wr && ir_q.sel == `SED_SEL_CTRL0 && !ext_debug_mode_en
		|=> ctrl0_q[30:0] == $past(ctrl0_q[30:0]))
		else $error("control bits changed on edm set");
	go_exec_a: assert property (go_cmd |=> exec_o && exec_instr_o == $past(scan_d))
		else $error("go did not execute scan");
	wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule // sed_debug_ctrl
`default_nettype wire

// ---- src/sed_pkg.sv ----
`default_nettype none
package sed_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} sed_tap_t;
	typedef struct packed {
		logic       rd;
		logic       go;
		logic       ex;
		logic [4:0] sel;
	} sed_cmd_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} sed_wb_req_t;
endpackage
`default_nettype wire

// ---- src/sed_regs.svh ----
`ifndef SED_REGS_SVH
`define SED_REGS_SVH
// Instruction register layout
`define SED_IR_LEN      8
`define SED_IR_RW       7
`define SED_IR_GO       6
`define SED_IR_EXIT     5
`define SED_IR_BYPASS   8'hFF
`define SED_IR_EXTEST   8'h00
`define SED_IR_SAMPLE   8'h01
// Register selects on the test port
`define SED_SEL_CTRL0   5'h00
`define SED_SEL_STAT    5'h01
`define SED_SEL_CNT     5'h02
`define SED_SEL_IAC     5'h04
`define SED_SEL_DAC     5'h08
`define SED_SEL_SCAN    5'h10
`define SED_SEL_ECTL    5'h12
// Bus byte addresses
`define SED_ADR_CTRL0   8'h00
`define SED_ADR_STAT    8'h04
`define SED_ADR_CNT     8'h08
`define SED_ADR_ESTAT   8'h0C
`define SED_ADR_IAC     8'h10
`define SED_ADR_DAC     8'h20
// Fields
`define SED_EDM_BIT     31
`define SED_ECTL_DR     0
`define SED_ECTL_CLK    1
`define SED_EV_N        8
`define SED_DR_LEN      32
`define SED_RST_WORD    32'h0000_0000
`define SED_RST_IR      8'hFF
`define SED_NSYNC       6
// Idle levels of the synchronised pins, tck low and tdi low
`define SED_SYNC_IDLE   6'h3A
`endif

// ---- verification/sed_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sed_cpu_model #(
	parameter int ACK_DLY = 3
) (
	// System
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Emulation side
	input  wire logic dbg_req_i,
	input  wire logic exec_i,
	output var  logic dbg_ack_o
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg_ack_o <= 1'b0;
			cnt_q     <= 4'h0;
		end else if (exec_i) begin
			dbg_ack_o <= 1'b0;
			cnt_q     <= 4'h0;
		end else if (dbg_req_i && !dbg_ack_o) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == ACK_DLY[3:0])
				dbg_ack_o <= 1'b1;
		end
	end
endmodule // sed_cpu_model
`default_nettype wire

// ---- verification/serial_external_debug_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sed_regs.svh"
module serial_external_debug_ctrl_bench;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	sed_pkg::sed_wb_req_t wb = '0;
	logic                 tck = 1'b0, tms = 1'b0, tdi = 1'b0, trst_n = 1'b1;
	logic                 emu_en = 1'b1, entry_n = 1'b1, jvld = 1'b0;
	logic [7:0]           ev = 8'h00, cap;
	logic [31:0]          wb_dat, instr, jword, w, o;
	logic                 ack, tdo, tdo_en, dack, req, irq, exec, sess_n, clk_rq, pub, ext_debug_mode_en;
	logic [31:0]          exp_q[$];
	int                   errors = 0, num_checks = 0, seed = 32'hd20a510a;

	always #50 clk = ~clk;

	sed_debug_ctrl i_sed_debug_ctrl (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb.cyc),
		.wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_adr_i(wb.adr), .wb_sel_i(wb.sel),
		.wb_dat_i(wb.dat), .wb_dat_o(wb_dat), .wb_ack_o(ack), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_en_o(tdo_en),
		.emu_enable_in_i(emu_en), .ext_debug_entry_n_i(entry_n), .dbg_ack_i(dack),
		.dbg_event_i(ev), .dbg_req_o(req), .debug_irq_o(irq), .exec_o(exec),
		.exec_instr_o(instr), .debug_session_n_o(sess_n), .cpu_clk_req_o(clk_rq),
		.public_instr_o(pub), .ext_debug_mode_en_o(ext_debug_mode_en));
	sed_cpu_model i_sed_cpu_model (.clk_i(clk), .rst_i(rst), .dbg_req_i(req), .exec_i(exec),
		.dbg_ack_o(dack));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bit_is(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Results in order: bus reads, executed words, test port reads
	always @(posedge clk) begin
		if ((ack === 1'b1 && !wb.we) || exec === 1'b1 || jvld) begin
			if (exp_q.size() == 0)
				check("result queue", 32'h1, 32'h0);
			else
				check("result", ack ? wb_dat : exec ? instr : jword, exp_q.pop_front());
		end
	end

	task automatic wb_io(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		if (!we)
			exp_q.push_back(d);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		wb <= '0;
		if (ack !== 1'b1)
			check("bus ack", 32'h0, 32'h1);
	endtask
	// One test clock period, stopped low between frames
	task automatic tick(input logic m, input logic di, output logic dout);
		tms <= m;
		tdi <= di;
		repeat (5) @(posedge clk);
		dout = tdo;
		tck <= 1'b1;
		repeat (3) @(posedge clk);
		tck <= 1'b0;
	endtask
	task automatic shift(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b0, b);
		if (ir)
			tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			if (i == 1)
				bit_is("tdo enable", tdo_en, 1'b1);
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		repeat (4) @(posedge clk);
		bit_is("tdo idle", tdo_en, 1'b0);
	endtask
	task automatic jtag(input sed_pkg::sed_cmd_t c, input logic [31:0] d,
		input logic [31:0] rd_exp);
		shift(1'b1, `SED_IR_LEN, {24'h0, c}, o);
		cap = o[7:0];
		shift(1'b0, `SED_DR_LEN, d, o);
		if (c.rd) begin
			exp_q.push_back(rd_exp);
			jword <= o;
			jvld  <= 1'b1;
			@(posedge clk);
			jvld <= 1'b0;
		end
	endtask
	task automatic wait_sess(input logic want);
		for (int n = 0; n < 80 && sess_n !== want; n++)
			@(posedge clk);
		bit_is("session flag", sess_n, want);
	endtask
	task automatic pulse_ev();
		ev <= 8'h01;
		@(posedge clk);
		ev <= 8'h00;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		wb_io(1'b0, `SED_ADR_CTRL0, 4'hF, `SED_RST_WORD);
		wb_io(1'b0, 8'h40, 4'hF, 32'h0);
		bit_is("idle session", sess_n, 1'b1);
		wb_io(1'b1, `SED_ADR_CTRL0, 4'hF, 32'h0000_0003);
		wb_io(1'b1, `SED_ADR_CTRL0, 4'h1, 32'hFFFF_FF0F);
		wb_io(1'b0, `SED_ADR_CTRL0, 4'hF, 32'h0000_000F);
		pulse_ev();
		bit_is("irq without mode", irq, 1'b1);
		bit_is("no halt without mode", req, 1'b0);
		wb_io(1'b0, `SED_ADR_STAT, 4'hF, 32'h0000_0001);
		$display("bus test over");
		tick(1'b0, 1'b0, cap[0]);
		jtag('{1'b0, 1'b0, 1'b0, `SED_SEL_ECTL}, 32'h3, 32'h0);
		bit_is("clock request", clk_rq, 1'b1);
		wait_sess(1'b0);
		jtag('{1'b0, 1'b0, 1'b0, `SED_SEL_STAT}, 32'h0, 32'h0);
		jtag('{1'b0, 1'b0, 1'b0, `SED_SEL_CTRL0}, 32'h8000_000F, 32'h0);
		check("capture", {29'h0, cap[2:0]}, 32'h3);
		bit_is("mode on", ext_debug_mode_en, 1'b1);
		wb_io(1'b1, `SED_ADR_CTRL0, 4'hF, 32'h0);
		w = $random(seed);
		wb_io(1'b1, `SED_ADR_CNT, 4'hF, w);
		wb_io(1'b0, `SED_ADR_CNT, 4'hF, 32'h0);
		wb_io(1'b0, `SED_ADR_CTRL0, 4'hF, 32'h8000_000F);
		jtag('{1'b1, 1'b0, 1'b0, `SED_SEL_CTRL0}, 32'h0, 32'h8000_000F);
		check("capture mode", {29'h0, cap[2:0]}, 32'h7);
		jtag('{1'b0, 1'b0, 1'b0, `SED_SEL_ECTL}, 32'h2, 32'h0);
		bit_is("request off", req, 1'b0);
		pulse_ev();
		bit_is("event halts", req, 1'b1);
		bit_is("irq held off", irq, 1'b0);
		jtag('{1'b0, 1'b0, 1'b0, `SED_SEL_STAT}, 32'h0, 32'h0);
		$display("mode test over");
		w = $random(seed);
		exp_q.push_back(w);
		jtag('{1'b0, 1'b1, 1'b0, `SED_SEL_SCAN}, w, 32'h0);
		repeat (12) @(posedge clk);
		bit_is("stay session", sess_n, 1'b0);
		bit_is("stay halted", dack, 1'b1);
		w = $random(seed);
		exp_q.push_back(w);
		jtag('{1'b0, 1'b1, 1'b1, `SED_SEL_SCAN}, w, 32'h0);
		wait_sess(1'b1);
		bit_is("exit request", req, 1'b0);
		entry_n <= 1'b0;
		wait_sess(1'b0);
		entry_n <= 1'b1;
		$display("go test over");
		emu_en <= 1'b0;
		repeat (3) @(posedge clk);
		pulse_ev();
		bit_is("mode blocked", ext_debug_mode_en, 1'b0);
		bit_is("events blocked", req, 1'b0);
		wb_io(1'b0, `SED_ADR_STAT, 4'hF, 32'h0);
		trst_n <= 1'b0;
		repeat (5) @(posedge clk);
		trst_n <= 1'b1;
		repeat (5) @(posedge clk);
		tick(1'b0, 1'b0, cap[0]);
		shift(1'b0, `SED_DR_LEN, 32'h0000_0001, o);
		check("bypass", o, 32'h0000_0002);
		shift(1'b1, `SED_IR_LEN, {24'h0, `SED_IR_EXTEST}, o);
		bit_is("public instr", pub, 1'b1);
		shift(1'b1, `SED_IR_LEN, {24'h0, `SED_IR_SAMPLE}, o);
		bit_is("sample instr", pub, 1'b1);
		shift(1'b1, `SED_IR_LEN, {24'h0, `SED_IR_BYPASS}, o);
		bit_is("bypass instr", pub, 1'b0);
		$display("port test over");
		give_verdict();
	end

	initial begin
		#2_000_000;
		check("watchdog", 32'h0, 32'h1);
		give_verdict();
	end
endmodule // serial_external_debug_ctrl_bench
`default_nettype wire
